// ---- vr_seq_defs.svh ----
// Purpose: Constants for the rail start-up sequencer and current report.
// Assumes: 125 MHz core clock, 8 ns period.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef VR_SEQ_DEFS_SVH
`define VR_SEQ_DEFS_SVH

`define CLK_PERIOD_NS 8
// Trim load and link enable after lockout clears
`define INIT_TIME_NS 1340000
`define INIT_CYCLES (`INIT_TIME_NS / `CLK_PERIOD_NS)
// Late-enable configuration period
`define CONFIG_TIME_NS 1000000
`define CONFIG_CYCLES (`CONFIG_TIME_NS / `CLK_PERIOD_NS)
// Current report refresh interval
`define REFRESH_TIME_NS 64000
`define REFRESH_CYCLES (`REFRESH_TIME_NS / `CLK_PERIOD_NS)
// Averaging window, in refresh slots (16 x 64 us)
`define WINDOW_SLOTS 16
`define WINDOW_SHIFT 4
// Converter samples per refresh slot, as a power of two
`define SAMPLE_SHIFT 6
// PWM duty limits in percent and eighths
`define DUTY_MAX_PCT 93
`define SOFT_DUTY_DIV 8
`define SOFT_PULSES 3'h4
// Switching period in clocks (1 MHz)
`define PWM_PERIOD 125
// Current ceiling: base in amps, step as a power of two
`define CEIL_BASE_MULTI 7'h40
`define CEIL_STEP_SHIFT 2
// Top of the voltage table in 5 mV codes
`define VID_TABLE_TOP 10'h0ff
// Largest dynamic offset: 0.64 V in 5 mV steps
`define DVC_MAX 8'h80
// Register defaults
`define BOOT_DEFAULT 8'h00
`define CTRL3_DEFAULT 2'h0
`define REPORT_DEFAULT 8'h01
`endif

// ---- vr_seq_pkg.sv ----
// Purpose: Types shared by the sequencer files.
// Assumes: Nothing beyond the defs header.
// Notes: Constants live in vr_seq_defs.svh.
package vr_seq_pkg;
	typedef enum logic [2:0] {seq_off, seq_init, seq_wait_en, seq_config, seq_run} seq_state_t;
endpackage

// ---- current_window_ram.sv ----
// Purpose: Slot memory for the sliding current average.
// Assumes: Single clock, one write and one read port.
// Notes: Read data is registered; contents are not reset.
module current_window_ram #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 7
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Plain storage, validity is tracked by the user
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ---- vr_startup_and_current_report.sv ----
// Purpose: Start-up sequencing, voltage target and load current report of one rail.
// Assumes: Pins uvlo_ok, enables and ramp_done are asynchronous; the rest is on clk.
// Notes: Analog sensing, ramp and error amplifier sit outside this block.
// Operation
// - Report word is 7 data bits, LSB one
// - Full scale of report equals current ceiling
// - Average over 1 ms, refresh every 64 us
// - Phase duty never exceeds 93 percent
// - Reject link request above voltage table
// - Dynamic offset in 5 mV steps, 0.64 V max
// - Link, SMBus and dynamic offsets all summed
// - Ceiling limits only link code and offset
// - Above-table targets do not arm OV/UV
// - Any undervoltage restores register defaults
// - Trim load, links enabled within 1.34 ms
// - Start needs both enables and lockout clear
// - Late enables add up to 1 ms config
// - Boot voltage defaults zero, SMBus may change
// - Zero target means no PWM pulses
// - Nonzero boot pulls alert low after soft start
// - First four pulses capped at 12.5 percent
// - Control register disables each droop source
// - Droop uses all configured phases
// - Ceiling steps 4 A up to 60/124 A
`include "vr_seq_defs.svh"

module vr_startup_and_current_report
	import vr_seq_pkg::*;
#(
	parameter int INIT_CYCLES = `INIT_CYCLES,
	parameter int CONFIG_CYCLES = `CONFIG_CYCLES,
	parameter int REFRESH_CYCLES = `REFRESH_CYCLES,
	parameter int PWM_PERIOD = `PWM_PERIOD
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic uvlo_ok,
	input wire logic [1:0] enable_inputs,
	input wire logic ramp_done,
	input wire logic [1:0] config_phases,
	input wire logic [3:0] ceiling_pin_code,
	input wire logic [6:0] current_sample,
	input wire logic [7:0] duty_request,
	input wire logic link_vid_write,
	input wire logic [7:0] link_vid_code,
	input wire logic [7:0] link_offset,
	input wire logic [7:0] link_vid_max,
	input wire logic smb_vid_write,
	input wire logic [7:0] smb_vid_code,
	input wire logic [7:0] smb_offset,
	input wire logic [7:0] dynamic_voltage_offset,
	input wire logic smb_boot_write,
	input wire logic [7:0] smb_boot_code,
	input wire logic smb_ctrl3_write,
	input wire logic [1:0] smb_ctrl3_data,
	output logic [7:0] load_current_word,
	output logic [6:0] current_ceiling,
	output logic links_enabled,
	output logic rails_running,
	output logic link_reject,
	output logic [9:0] target_code,
	output logic ovuv_arm,
	output logic pwm_out,
	output logic alert_out,
	output logic alert_oe_n,
	output logic [1:0] droop_enable,
	output logic [1:0] droop_phase_count
);
	localparam logic [7:0] MAX_ON = 8'((PWM_PERIOD * `DUTY_MAX_PCT) / 100);
	localparam logic [7:0] SOFT_ON = 8'(PWM_PERIOD / `SOFT_DUTY_DIV);

	if (PWM_PERIOD < 8 || PWM_PERIOD > 255) begin : g_bad_period
		$error("PWM_PERIOD must be 8 to 255");
	end
	if (INIT_CYCLES < 1 || CONFIG_CYCLES < 1 || REFRESH_CYCLES < 1) begin : g_bad_time
		$error("timing counts must be at least one");
	end

	// Full-width add of link code and offset, then ceiling clamp
	function automatic logic [9:0] link_part(input logic [7:0] vid, input logic [7:0] off,
			input logic [7:0] vmax);
		logic [9:0] sum;
		sum = {2'h0, vid} + {2'h0, off};
		link_part = (sum > {2'h0, vmax}) ? {2'h0, vmax} : sum;
	endfunction

	// Two-flop synchronisers for the asynchronous pins
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	always_ff @(posedge clk) begin
		if (reset) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end else begin
			sync_a <= {ramp_done, enable_inputs, uvlo_ok};
			sync_b <= sync_a;
		end
	end

	logic supply_ok;
	logic enables_ok;
	logic ramp_ok;
	assign supply_ok = sync_b[0];
	assign enables_ok = &sync_b[2:1];
	assign ramp_ok = sync_b[3];

	// Start-up sequence
	seq_state_t state;
	logic [17:0] seq_cnt;
	logic init_done;
	always_ff @(posedge clk) begin
		if (reset || !supply_ok) begin
			state <= seq_off;
			seq_cnt <= 18'h0;
			init_done <= 1'b0;
		end else begin
			case (state)
				seq_off: begin
					state <= seq_init;
					seq_cnt <= 18'h0;
				end
				seq_init: begin
					// Trim bits load, then links come up
					if (seq_cnt == 18'(INIT_CYCLES - 1)) begin
						init_done <= 1'b1;
						seq_cnt <= 18'h0;
						state <= enables_ok ? seq_run : seq_wait_en;
					end else begin
						seq_cnt <= seq_cnt + 18'h1;
					end
				end
				seq_wait_en: begin
					// Enables arriving late cost a pin configuration period
					if (enables_ok) begin
						state <= seq_config;
					end
				end
				seq_config: begin
					if (!enables_ok) begin
						state <= seq_wait_en;
						seq_cnt <= 18'h0;
					end else if (seq_cnt == 18'(CONFIG_CYCLES - 1)) begin
						seq_cnt <= 18'h0;
						state <= seq_run;
					end else begin
						seq_cnt <= seq_cnt + 18'h1;
					end
				end
				seq_run: begin
					if (!enables_ok) begin
						state <= seq_wait_en;
					end
				end
				default: state <= seq_off;
			endcase
		end
	end

	// Either undervoltage drops the data registers to defaults
	logic regs_clear;
	assign regs_clear = reset || !supply_ok || !enables_ok;

	logic [7:0] boot_code;
	logic [1:0] ctrl3;
	always_ff @(posedge clk) begin
		if (regs_clear) begin
			boot_code <= `BOOT_DEFAULT;
			ctrl3 <= `CTRL3_DEFAULT;
		end else begin
			if (smb_boot_write && init_done) begin
				boot_code <= smb_boot_code;
			end
			if (smb_ctrl3_write && init_done) begin
				ctrl3 <= smb_ctrl3_data;
			end
		end
	end

	// Pin-programmed ceiling, latched as the rail starts
	logic [3:0] ceil_code;
	always_ff @(posedge clk) begin
		if (regs_clear) begin
			ceil_code <= 4'h0;
		end else if (state != seq_run) begin
			ceil_code <= ceiling_pin_code;
		end
	end

	// Voltage code and link offset; boot code loads on start
	logic [7:0] vid_code;
	logic [7:0] link_off;
	logic in_run;
	logic next_reject;
	assign in_run = (state == seq_run);
	assign next_reject = ({1'b0, link_vid_code} + {1'b0, link_offset}) > 9'(`VID_TABLE_TOP);
	always_ff @(posedge clk) begin
		if (regs_clear || !in_run) begin
			vid_code <= boot_code;
			link_off <= 8'h0;
			link_reject <= 1'b0;
		end else begin
			link_reject <= 1'b0;
			if (link_vid_write) begin
				// A rolled-over table code is refused whole
				if (next_reject) begin
					link_reject <= 1'b1;
				end else begin
					vid_code <= link_vid_code;
					link_off <= link_offset;
				end
			end else if (smb_vid_write) begin
				vid_code <= smb_vid_code;
			end
		end
	end

	// Target: clamped link part plus unclamped SMBus offset and dynamic offset capped at DVC_MAX
	logic [7:0] dvc_clamped;
	logic [9:0] next_target;
	assign dvc_clamped = (dynamic_voltage_offset > `DVC_MAX) ? `DVC_MAX : dynamic_voltage_offset;
	assign next_target = (vid_code == 8'h0) ? 10'h0 :
		link_part(vid_code, link_off, link_vid_max) + {2'h0, smb_offset} + {2'h0, dvc_clamped};
	always_ff @(posedge clk) begin
		if (reset) begin
			target_code <= 10'h0;
			ovuv_arm <= 1'b0;
		end else begin
			target_code <= next_target;
			// Over-table targets leave the fault comparators idle
			ovuv_arm <= in_run && next_target != 10'h0 && next_target <= `VID_TABLE_TOP;
		end
	end

	// PWM with soft-start cap and bootstrap limit
	logic [7:0] pwm_cnt;
	logic [2:0] pulse_cnt;
	logic pwm_active;
	logic [7:0] on_limit;
	logic soft_period;
	assign pwm_active = in_run && (vid_code != 8'h0);
	// Limit held for a whole period, so the fourth pulse cannot widen mid-period
	assign on_limit = soft_period ? SOFT_ON : MAX_ON;
	always_ff @(posedge clk) begin
		if (reset || !pwm_active) begin
			pwm_cnt <= 8'h0;
			pulse_cnt <= 3'h0;
			pwm_out <= 1'b0;
			soft_period <= 1'b1;
		end else begin
			if (pwm_cnt == 8'h0) begin
				soft_period <= (pulse_cnt < `SOFT_PULSES);
			end
			pwm_cnt <= (pwm_cnt == 8'(PWM_PERIOD - 1)) ? 8'h0 : pwm_cnt + 8'h1;
			pwm_out <= (pwm_cnt < duty_request) && (pwm_cnt < on_limit);
			// Count pulses that really fired; one-cycle requests count too
			if (pwm_cnt == 8'h0 && duty_request != 8'h0 && pulse_cnt < `SOFT_PULSES) begin
				pulse_cnt <= pulse_cnt + 3'h1;
			end
		end
	end

	// Alert pulled low after soft start with a nonzero boot code
	always_ff @(posedge clk) begin
		if (reset) begin
			alert_out <= 1'b0;
			alert_oe_n <= 1'b1;
		end else begin
			alert_out <= 1'b0;
			alert_oe_n <= !(in_run && boot_code != 8'h0 && ramp_ok && pulse_cnt == `SOFT_PULSES);
		end
	end

	// Loose status and droop controls
	always_ff @(posedge clk) begin
		if (reset) begin
			links_enabled <= 1'b0;
			rails_running <= 1'b0;
			droop_enable <= 2'h3;
			droop_phase_count <= 2'h1;
			current_ceiling <= 7'h0;
		end else begin
			links_enabled <= init_done;
			rails_running <= in_run;
			droop_enable <= ~ctrl3;
			// Configured, not active, phases keep the load line constant
			droop_phase_count <= (config_phases == 2'h0) ? 2'h1 : config_phases;
			current_ceiling <= ((config_phases > 2'h1) ? `CEIL_BASE_MULTI : 7'h0)
				+ {1'b0, ceil_code, 2'h0};
		end
	end

	// Sample, slot and window timing
	localparam int SAMPLE_DIV = REFRESH_CYCLES >> `SAMPLE_SHIFT;
	if (SAMPLE_DIV < 1) begin : g_bad_refresh
		$error("REFRESH_CYCLES too small for the sample count");
	end
	logic [15:0] samp_div;
	logic [15:0] slot_div;
	logic sample_tick;
	logic slot_tick;
	assign sample_tick = (samp_div == 16'(SAMPLE_DIV - 1));
	assign slot_tick = (slot_div == 16'(REFRESH_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (reset) begin
			samp_div <= 16'h0;
			slot_div <= 16'h0;
		end else begin
			samp_div <= (sample_tick || slot_tick) ? 16'h0 : samp_div + 16'h1;
			slot_div <= slot_tick ? 16'h0 : slot_div + 16'h1;
		end
	end

	// Per-slot sample sum; the analog side scales to the ceiling
	logic [12:0] slot_sum;
	logic [12:0] slot_full;
	logic [6:0] slot_avg;
	// Last sample of a slot arrives with the tick; dropping it reads short of full scale
	assign slot_full = slot_sum + (sample_tick ? {6'h0, current_sample} : 13'h0);
	assign slot_avg = slot_full[12:6];
	always_ff @(posedge clk) begin
		if (reset || slot_tick) begin
			slot_sum <= 13'h0;
		end else if (sample_tick) begin
			slot_sum <= slot_sum + {6'h0, current_sample};
		end
	end

	// Sliding window over the last sixteen slots
	logic [3:0] slot_ptr;
	logic [15:0] slot_valid;
	logic [6:0] old_avg;
	logic [6:0] ram_rdata;
	logic [10:0] win_total;
	logic [10:0] next_total;
	assign old_avg = slot_valid[slot_ptr] ? ram_rdata : 7'h0;
	assign next_total = win_total - {4'h0, old_avg} + {4'h0, slot_avg};

	current_window_ram #(
		.DEPTH(`WINDOW_SLOTS),
		.WIDTH(7)
	) u_window (
		.clk(clk),
		.wr_en(slot_tick),
		.wr_addr(slot_ptr),
		.wr_data(slot_avg),
		.rd_addr(slot_ptr),
		.rd_data(ram_rdata)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			slot_ptr <= 4'h0;
			slot_valid <= 16'h0;
			win_total <= 11'h0;
			load_current_word <= `REPORT_DEFAULT;
		end else if (slot_tick) begin
			slot_ptr <= slot_ptr + 4'h1;
			slot_valid[slot_ptr] <= 1'b1;
			win_total <= next_total;
			// Whole word replaced at once, so reads never tear
			load_current_word <= {next_total[10:4], 1'b1};
		end
	end

	// Checks
	AST_LSB_ONE: assert property (@(posedge clk) disable iff (reset) load_current_word[0])
		else $error("report lsb not one");
	AST_REPORT_STABLE: assert property (@(posedge clk) disable iff (reset)
		!slot_tick |=> $stable(load_current_word))
		else $error("report changed between refreshes");
	AST_REFRESH_PERIOD: assert property (@(posedge clk) disable iff (reset)
		slot_tick |=> !slot_tick [*8])
		else $error("refresh came too soon");
	AST_DUTY_MAX: assert property (@(posedge clk) disable iff (reset)
		pwm_out |-> $past(pwm_cnt) < MAX_ON)
		else $error("duty above limit");
	AST_SOFT_DUTY: assert property (@(posedge clk) disable iff (reset)
		pwm_out && $past(pulse_cnt) < `SOFT_PULSES |-> $past(pwm_cnt) < SOFT_ON)
		else $error("soft start pulse too wide");
	AST_REJECT: assert property (@(posedge clk) disable iff (reset)
		in_run && link_vid_write && next_reject && !regs_clear |=> link_reject && $stable(vid_code))
		else $error("over-table request not refused");
	AST_NO_PWM_ZERO: assert property (@(posedge clk) disable iff (reset)
		vid_code == 8'h0 |=> !pwm_out)
		else $error("pulse with zero target");
	AST_OVUV: assert property (@(posedge clk) disable iff (reset)
		next_target > `VID_TABLE_TOP |=> !ovuv_arm)
		else $error("over-table target armed faults");
	AST_DEFAULTS: assert property (@(posedge clk) disable iff (reset)
		!enables_ok |=> boot_code == `BOOT_DEFAULT && ctrl3 == `CTRL3_DEFAULT)
		else $error("registers not restored");
	AST_NO_EARLY_RUN: assert property (@(posedge clk) disable iff (reset)
		$rose(in_run) |-> init_done && $past(enables_ok))
		else $error("rail started too early");
	AST_DROOP: assert property (@(posedge clk) disable iff (reset)
		smb_ctrl3_write && init_done && !regs_clear |=> ##1 droop_enable == ~$past(smb_ctrl3_data, 2))
		else $error("droop control not applied");
	AST_CEILING: assert property (@(posedge clk) disable iff (reset)
		current_ceiling[1:0] == 2'h0)
		else $error("ceiling off the 4 A grid");

	COV_RUN: cover property (@(posedge clk) disable iff (reset) $rose(in_run));
	COV_LATE_CONFIG: cover property (@(posedge clk) disable iff (reset) state == seq_config);
	COV_REJECT: cover property (@(posedge clk) disable iff (reset) link_reject);
	COV_ALERT: cover property (@(posedge clk) disable iff (reset) $fell(alert_oe_n));
endmodule

// ---- vr_link_host.sv ----
// Purpose: Processor side of the voltage link, issues voltage requests.
// Assumes: Requests are one-cycle strobes launched just after a clock edge.
// Notes: Released code and offset lines show the inverse of the last value.
module vr_link_host (
	input wire logic clk,
	output logic link_vid_write,
	output logic [7:0] link_vid_code,
	output logic [7:0] link_offset
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle link after power-up
	initial begin
		link_vid_write = 1'b0;
		link_vid_code = 8'h00;
		link_offset = 8'h00;
	end

	// One request; a non-zero code starts a zero-boot rail
	task automatic send(input logic [7:0] code, input logic [7:0] offset);
		@(posedge clk);
		#1;
		link_vid_write = 1'b1;
		link_vid_code = code;
		link_offset = offset;
		@(posedge clk);
		#1;
		link_vid_write = 1'b0;
		link_vid_code = ~code; // Stale data must not look valid
		link_offset = ~offset;
	endtask
endmodule

// ---- vr_startup_and_current_report_tb_top.sv ----
// Purpose: Self-checking bench for start-up, voltage target and current report.
// Assumes: Shortened counts: init 50, config 40, refresh 128, PWM period 16.
// Notes: Sequencing cases first, then link row table, then hand-written target, PWM and report cases.
module vr_startup_and_current_report_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] vid; logic [7:0] off; logic rej; logic [9:0] tgt;} link_row_t;
	logic clk, reset, uvlo_ok, ramp_done, smb_vid_write, smb_boot_write, smb_ctrl3_write;
	logic [1:0] enable_inputs, config_phases, smb_ctrl3_data, droop_enable, droop_phase_count;
	logic [3:0] ceiling_pin_code;
	logic [6:0] current_sample, current_ceiling;
	logic [7:0] duty_request, link_vid_max, smb_vid_code, smb_offset, dynamic_voltage_offset;
	logic [7:0] smb_boot_code, load_current_word, link_vid_code, link_offset;
	logic link_vid_write, links_enabled, rails_running, link_reject, ovuv_arm, pwm_out;
	logic alert_out, alert_oe_n;
	logic [9:0] target_code;
	int num_errors, total_checks, hi, k;
	link_row_t rows[3] = '{'{8'h40, 8'h10, 1'b0, 10'h050}, '{8'hf0, 8'h0f, 1'b0, 10'h0ff},
		'{8'hf0, 8'h10, 1'b1, 10'h0ff}};

	vr_startup_and_current_report #(.INIT_CYCLES(50), .CONFIG_CYCLES(40), .REFRESH_CYCLES(128),
		.PWM_PERIOD(16)) i_dut (.clk, .reset, .uvlo_ok, .enable_inputs, .ramp_done,
		.config_phases, .ceiling_pin_code, .current_sample, .duty_request, .link_vid_write,
		.link_vid_code, .link_offset, .link_vid_max, .smb_vid_write, .smb_vid_code, .smb_offset,
		.dynamic_voltage_offset, .smb_boot_write, .smb_boot_code, .smb_ctrl3_write,
		.smb_ctrl3_data, .load_current_word, .current_ceiling, .links_enabled, .rails_running,
		.link_reject, .target_code, .ovuv_arm, .pwm_out, .alert_out, .alert_oe_n, .droop_enable,
		.droop_phase_count);
	vr_link_host i_host (.clk, .link_vid_write, .link_vid_code, .link_offset);

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (num_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	function automatic logic sig(input int sel);
		case (sel)
			0: return links_enabled;
			1: return rails_running;
			2: return pwm_out;
			default: return ~alert_oe_n;
		endcase
	endfunction

	// Bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_on(input int sel);
		for (k = 0; k < 400 && sig(sel) !== 1'b1; k++) tick(1);
		if (sig(sel) !== 1'b1) begin
			num_errors++;
			complete_run();
		end
	endtask

	task automatic count_pwm(input int len);
		hi = 0;
		repeat (len) begin
			tick(1);
			if (pwm_out === 1'b1) hi++;
		end
	endtask

	// Main sequence
	initial begin
		{reset, uvlo_ok, ramp_done, smb_vid_write, smb_boot_write, smb_ctrl3_write} = 6'h20;
		{enable_inputs, smb_ctrl3_data, smb_vid_code, smb_offset, smb_boot_code} = '0;
		dynamic_voltage_offset = 8'h00;
		config_phases = 2'h2;
		ceiling_pin_code = 4'hf;
		current_sample = 7'h7f; // Full scale sample from the start
		duty_request = 8'h10; // Asks for the whole period
		link_vid_max = 8'hff;
		tick(12);
		reset = 1'b0;
		check(load_current_word, 8'h01);
		check({droop_enable, alert_oe_n, links_enabled}, 4'he);
		// Lockout clears first, enables come late
		uvlo_ok = 1'b1;
		wait_on(0);
		check(rails_running, 1'b0);
		tick(10);
		enable_inputs = 2'h3;
		tick(35);
		check(rails_running, 1'b0);
		wait_on(1);
		check(current_ceiling, 7'h7c);
		check(droop_phase_count, 2'h2);
		count_pwm(40);
		check(16'(hi), 16'h0);
		smb_ctrl3_write = 1'b1;
		smb_ctrl3_data = 2'h1;
		tick(1);
		smb_ctrl3_write = 1'b0;
		tick(3);
		check(droop_enable, 2'h2);
		// Link request rows: accept, table top, rollover
		foreach (rows[i]) begin
			i_host.send(rows[i].vid, rows[i].off);
			check(link_reject, rows[i].rej);
			tick(1);
			check(target_code, rows[i].tgt);
			check(ovuv_arm, 1'b1);
		end
		// Offsets summed; ceiling clamps only the link part
		smb_offset = 8'h05;
		dynamic_voltage_offset = 8'h90;
		tick(4);
		check(target_code, 10'h184);
		check(ovuv_arm, 1'b0);
		link_vid_max = 8'h20;
		tick(4);
		check(target_code, 10'h0a5);
		// Let the four soft-start periods pass first
		tick(64);
		count_pwm(16);
		check(16'(hi), 16'he);
		smb_boot_write = 1'b1;
		smb_boot_code = 8'h30;
		ramp_done = 1'b1;
		tick(1);
		smb_boot_write = 1'b0;
		wait_on(3);
		check(alert_out, 1'b0);
		// Report settles to full scale, then to zero
		tick(2600);
		check(load_current_word, 8'hff);
		current_sample = 7'h00;
		tick(2600);
		check(load_current_word, 8'h01);
		// Enable drop clears boot and control, then soft restart
		enable_inputs = 2'h0;
		tick(5);
		check({rails_running, droop_enable, alert_oe_n}, 4'h7);
		enable_inputs = 2'h3;
		wait_on(1);
		count_pwm(40);
		check(16'(hi), 16'h0);
		i_host.send(8'h40, 8'h00);
		wait_on(2);
		hi = 1;
		repeat (63) begin
			tick(1);
			if (pwm_out === 1'b1) hi++;
		end
		check(16'(hi), 16'h8);
		complete_run();
	end
endmodule
